/* silp_pkg.sv */
package silp_pkg;

  // widths of the shift path and the storage latch
  localparam int SILP_WIDTH = 8;
  localparam logic [7:0] SILP_SHIFT_RST = 8'h00;
  localparam logic [7:0] SILP_LATCH_RST = 8'h00;
  localparam int SILP_LAST_STAGE = 7;

  // drive enables of the parallel pins and reset values of the pin flops
  localparam logic [7:0] SILP_PAR_DRIVE = 8'hff;
  localparam logic [7:0] SILP_PAR_FLOAT = 8'h00;
  localparam logic SILP_CASC_RST = 1'h0;
  localparam logic SILP_CASC_DRIVE = 1'h1;

  // synchroniser reset values; the enable comes up inactive
  localparam logic [2:0] SILP_LC_SYNC_RST = 3'h0;
  localparam logic [1:0] SILP_OE_SYNC_RST = 2'h3;

  // pin-level view of the parallel outputs
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] oe;
  } silp_par_type;

  // state of the latch-clock edge detector
  typedef enum logic [1:0] {
    SILP_LC_IDLE,
    SILP_LC_HIGH
  } silp_lc_state_type;

endpackage

/* silp_shift.sv */
`timescale 1ns/1ns
module silp_shift
  import silp_pkg::*;
(
  input wire logic shift_clk_i,
  input wire logic reset_i,
  input wire logic serial_in_i,
  output logic [7:0] stages_o
);

  ////////////////////////////////////////////////////////////////////////
  // stage 0 takes the pin, every later stage its left neighbour
  always_ff @(posedge shift_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      stages_o <= SILP_SHIFT_RST;
    end
    else
    begin
      stages_o <= {stages_o[6:0], serial_in_i};
    end
  end

  AST_SHIFT_MOVE: assert property (@(posedge shift_clk_i) disable iff (reset_i)
    ##1 stages_o[7:1] == $past(stages_o[6:0]))
    else $error("shift stage did not take its neighbour");

  AST_SHIFT_CAPTURE: assert property (@(posedge shift_clk_i) disable iff (reset_i)
    ##1 stages_o[0] == $past(serial_in_i))
    else $error("first stage missed serial input");

endmodule // silp_shift

/* silp_top.sv */
`timescale 1ns/1ns
// Overview of operation
// - each rising shift clock loads serial input into the eight-stage register
// - reset low clears the shift register at once, no clock needed
// - reset leaves the storage latch untouched
// - each rising latch clock copies all eight stages into the latch
// - output enable low drives latch contents onto the parallel outputs
// - output enable high floats all eight parallel outputs
// - output enable never affects the serial cascade output
// - parallel outputs show latch bits uninverted, with three-state ability
// - cascade output carries the eighth stage uninverted
// - cascade output is always driven, never floating
module silp_top
  import silp_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic shift_clk_i,
  input wire logic shift_reset_n_i,
  input wire logic serial_in_i,
  input wire logic latch_clk_i,
  input wire logic out_enable_n_i,
  output logic [7:0] par_data_o,
  output logic [7:0] par_oe_o,
  output logic serial_cascade_out_o,
  output logic serial_cascade_oe_o
);

  // link-side word, its two core-side copies and the shift reset
  logic [7:0] stages;
  logic [7:0] stage_sync1;
  logic [7:0] stage_sync2;
  logic shift_rst;
  // control pin synchronisers, the edge they yield and the storage
  logic [2:0] lc_sync;
  logic [1:0] oe_sync;
  logic [7:0] latch;
  logic lc_rise;
  silp_lc_state_type lc_state;
  silp_par_type par;

  ////////////////////////////////////////////////////////////////////////
  // shift register lives on the link clock; its reset must stay async
  // either reset clears the stages; only the chip reset clears the latch
  assign shift_rst = reset_i | ~shift_reset_n_i;

  silp_shift u_shift (
    .shift_clk_i(shift_clk_i),
    .reset_i(shift_rst),
    .serial_in_i(serial_in_i),
    .stages_o(stages)
  );

  ////////////////////////////////////////////////////////////////////////
  // bring stages over; host keeps them still around the latch edge,
  // so a two-stage level crossing is enough for the word
  // limitation: shifting within four core cycles of a latch edge may
  // tear the word, since no handshake guards it
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      stage_sync1 <= SILP_SHIFT_RST;
      stage_sync2 <= SILP_SHIFT_RST;
    end
    else
    begin
      stage_sync1 <= stages;
      stage_sync2 <= stage_sync1;
    end
  end

  // the enable pin passes two flops and the latch clock three before any use;
  // the enable starts inactive so the pins float out of reset
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      lc_sync <= SILP_LC_SYNC_RST;
      oe_sync <= SILP_OE_SYNC_RST;
    end
    else
    begin
      lc_sync <= {lc_sync[1:0], latch_clk_i};
      oe_sync <= {oe_sync[0], out_enable_n_i};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // latch clock rising edge detector on the system clock
  // a latch pulse under one core cycle may slip past unseen
  assign lc_rise = (lc_state == SILP_LC_IDLE) && lc_sync[2];

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      lc_state <= SILP_LC_IDLE;
    end
    else
    begin
      unique case (lc_state)
        SILP_LC_IDLE: if (lc_sync[2]) lc_state <= SILP_LC_HIGH;
        SILP_LC_HIGH: if (!lc_sync[2]) lc_state <= SILP_LC_IDLE;
      endcase
    end
  end

  // storage latch; only the chip reset clears it, never the shift reset
  // the latch lives on the core side, out of the shift reset's reach
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      latch <= SILP_LATCH_RST;
    end
    else if (lc_rise)
    begin
      latch <= stage_sync2;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin drivers, registered so outputs come from flops
  always_comb
  begin
    par.data = latch;
    par.oe = oe_sync[1] ? SILP_PAR_FLOAT : SILP_PAR_DRIVE;
  end

  // parallel pins float from reset until the enable has been seen low
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      par_data_o <= SILP_LATCH_RST;
      par_oe_o <= SILP_PAR_FLOAT;
    end
    else
    begin
      par_data_o <= par.data;
      par_oe_o <= par.oe;
    end
  end

  // cascade pin kept apart so the parallel enable can never reach it;
  // it reads the second sync flop, the link-side stage being unsafe here
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      serial_cascade_out_o <= SILP_CASC_RST;
      serial_cascade_oe_o <= SILP_CASC_DRIVE;
    end
    else
    begin
      serial_cascade_out_o <= stage_sync2[SILP_LAST_STAGE];
      serial_cascade_oe_o <= SILP_CASC_DRIVE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks on the shift register, the edge detector, the latch, the pin drivers and the cascade output

  AST_LATCH_LOAD: assert property (@(posedge core_clk_i) disable iff (reset_i)
    lc_rise |=> latch == $past(stage_sync2))
    else $error("latch did not load the stages");

  AST_LATCH_HOLD: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !lc_rise |=> $stable(latch))
    else $error("latch changed without latch edge");

  AST_OE_ON: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !oe_sync[1] |=> par_oe_o == SILP_PAR_DRIVE && par_data_o == $past(latch))
    else $error("outputs not driven with latch");

  AST_OE_OFF: assert property (@(posedge core_clk_i) disable iff (reset_i)
    oe_sync[1] |=> par_oe_o == SILP_PAR_FLOAT)
    else $error("outputs not floated");

  AST_CASCADE_DRIVEN: assert property (@(posedge core_clk_i) disable iff (reset_i)
    serial_cascade_oe_o)
    else $error("cascade output floating");

  AST_EDGE_ONCE: assert property (@(posedge core_clk_i) disable iff (reset_i)
    lc_rise |=> !lc_rise)
    else $error("latch edge seen twice");

  AST_SHIFT_CLEAR: assert property (@(posedge core_clk_i) disable iff (reset_i)
    shift_rst |-> stages == SILP_SHIFT_RST)
    else $error("shift register not cleared in reset");

  AST_CASCADE_FOLLOW: assert property (@(posedge core_clk_i) disable iff (reset_i)
    1'h1 |=> serial_cascade_out_o == $past(stage_sync2[SILP_LAST_STAGE]))
    else $error("cascade output lost the last stage");

  AST_CASCADE_NO_OE: assert property (@(posedge core_clk_i) disable iff (reset_i)
    $changed(oe_sync[1]) && $stable(stage_sync2) |=> $stable(serial_cascade_out_o))
    else $error("cascade output moved with the enable");

  AST_PAR_DATA: assert property (@(posedge core_clk_i) disable iff (reset_i)
    1'h1 |=> par_data_o == $past(latch))
    else $error("parallel data not the latch uninverted");

  AST_OE_FOLLOW: assert property (@(posedge core_clk_i) disable iff (reset_i)
    $changed(oe_sync[1]) |=> $changed(par_oe_o))
    else $error("pin enables did not follow the enable input");

  AST_WORD_STILL: assert property (@(posedge core_clk_i) disable iff (reset_i)
    lc_rise |-> stage_sync1 == stage_sync2)
    else $error("stage word moving at the latch edge");

  AST_EDGE_FROM_LOW: assert property (@(posedge core_clk_i) disable iff (reset_i)
    lc_rise |-> !$past(lc_sync[2]))
    else $error("latch edge without a low level before it");

  AST_SRST_KEEPS_LATCH: assert property (@(posedge core_clk_i) disable iff (reset_i)
    shift_rst && !lc_rise |=> latch == $past(latch))
    else $error("shift reset disturbed the latch");

endmodule // silp_top

/* silp_host.sv */
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////
// host port model: shift clock stands still between frames
module silp_host (
  output logic shift_clk_o,
  output logic serial_o
);
  initial
  begin
    shift_clk_o = 1'b0;
    serial_o = 1'b0;
  end
  // msb first, bit set up half a period before the rise
  task automatic send(input logic [7:0] b);
    #7; // link edges kept off the core edges
    for (int i = 7; i >= 0; i--)
    begin
      serial_o = b[i];
      #80 shift_clk_o = 1'b1;
      #80 shift_clk_o = 1'b0;
    end
    serial_o = ~b[0]; // line not held after the frame
  endtask
endmodule // silp_host

/* silp_top_test.sv */
`timescale 1ns/1ns
module silp_top_test;
  import silp_pkg::*;
  logic core_clk_i = 1'b0, reset_i = 1'b1, shift_reset_n_i = 1'b1;
  logic latch_clk_i = 1'b0, out_enable_n_i = 1'b1;
  logic shift_clk, serial, casc, casc_oe;
  logic [7:0] par_data, par_oe, b, sr = 8'h00, lat = 8'h00;
  int fails = 0, compares = 0, seed = 80, cycles = 0;
  silp_host u_silp_host (.shift_clk_o(shift_clk), .serial_o(serial));
  silp_top u_silp_top (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .shift_clk_i(shift_clk), .shift_reset_n_i(shift_reset_n_i),
    .serial_in_i(serial), .latch_clk_i(latch_clk_i),
    .out_enable_n_i(out_enable_n_i), .par_data_o(par_data), .par_oe_o(par_oe),
    .serial_cascade_out_o(casc), .serial_cascade_oe_o(casc_oe));
  ////////////////////////////////////////////////////////////////
  // core clock, 100 ns
  initial forever #50 core_clk_i = ~core_clk_i;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // drives land on the rising edge, samples on the falling one
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  // watchdog, a run needs about 250 cycles
  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////
  // frames of random data against the integer model
  initial
  begin
    cyc(20);
    reset_i <= 1'b0;
    cyc(2);
    // pins out of reset: floating, latch and cascade clear
    @(negedge core_clk_i);
    check(par_data, SILP_LATCH_RST);
    check(par_oe, 8'h00);
    check({7'h00, casc}, 8'h00);
    check({7'h00, casc_oe}, 8'h01);
    for (int n = 0; n < 8; n++)
    begin
      b = 8'($random(seed));
      u_silp_host.send(b);
      // model: msb first into stage 0, all others move one up
      for (int i = 7; i >= 0; i--)
        sr = {sr[6:0], b[i]};
      cyc(4);
      @(negedge core_clk_i);
      check({7'h00, casc}, {7'h00, sr[7]});
      if (n[0])
      begin
        cyc(1);
        shift_reset_n_i <= 1'b0;
        cyc(3);
        @(negedge core_clk_i);
        sr = 8'h00;
        check({7'h00, casc}, 8'h00);
        check(par_data, lat);
        cyc(1);
        shift_reset_n_i <= 1'b1;
      end
      cyc(1);
      latch_clk_i <= 1'b1;
      cyc(3);
      latch_clk_i <= 1'b0;
      out_enable_n_i <= n[1];
      lat = sr;
      cyc(5);
      @(negedge core_clk_i);
      check(par_data, lat);
      check(par_oe, n[1] ? 8'h00 : 8'hff);
      check({7'h00, casc_oe}, 8'h01);
      check({7'h00, casc}, {7'h00, sr[7]});
      $display("test %0d done", n);
    end
    final_report();
  end
endmodule // silp_top_test
